/* File: hw/cfmc_pkg.sv */
// constants shared by the configurable macrocell block
package cfmc_pkg;
  // number of storage elements held by the block
  localparam int NUM_STORE = 6;
  // storage element indices
  localparam int IDX_TWO_A = 0;
  localparam int IDX_TWO_B = 1;
  localparam int IDX_THREE_A = 2;
  localparam int IDX_THREE_B = 3;
  localparam int IDX_STORE_A = 4;
  localparam int IDX_STORE_B = 5;
  // two-input cell data field when used as storage
  localparam int TWO_MODE_BIT = 0;
  localparam int TWO_POL_BIT = 1;
  localparam int TWO_INIT_BIT = 2;
  // three-input cell data field when used as storage
  localparam int THREE_MODE_BIT = 0;
  localparam int THREE_POL_BIT = 1;
  localparam int THREE_SR_BIT = 2;
  localparam int THREE_INIT_BIT = 3;
  // standalone storage configuration field
  localparam int ALONE_MODE_BIT = 0;
  localparam int ALONE_SR_BIT = 1;
  localparam int ALONE_INIT_BIT = 2;
  // matrix input positions of a storage cell
  localparam int IN_DATA = 0;
  localparam int IN_CLK = 1;
  localparam int IN_CTL = 2;
  // function select, storage mode and set/reset encodings
  localparam logic FUNC_LUT = 1'b0;
  localparam logic FUNC_STORE = 1'b1;
  localparam logic FUNC_PATTERN = 1'b1;
  localparam logic MODE_DFF = 1'b0;
  localparam logic MODE_LATCH = 1'b1;
  localparam logic SR_RESET = 1'b0;
  // pattern generator reset index and clock input position
  localparam logic [3:0] PAT_IDX_RESET = 4'h0;
  localparam int PAT_CLK_IN = 0;
endpackage : cfmc_pkg

/* File: hw/cfmc_macrocells.sv */
// configurable lookup / flip-flop / latch / pattern macrocells
//
// Functional notes
// - two-input cell: select 0 lookup, 1 storage
// - four data bits: truth table or storage settings
// - mode bit 0 edge flop, 1 transparent latch
// - polarity bit 1 inverts the storage output
// - power-on reset holds configured initial state
// - leftover lookup bits ignored in storage use
// - three-input cell: eight-bit table or storage
// - control input high: reset if set/reset bit is 0, set if 1
// - standalone cells always storage, three settings
// - four-input cell: lookup or pattern generator
// - sixteen bits: truth table or emitted pattern
// - four-bit count sets pattern repeat length
`timescale 1ns/1ps
module cfmc_macrocells (
  // system clock, power-on reset and clock enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // two-input cell configuration
  input wire logic [3:0] CFG_TWO_A_DATA,
  input wire logic CFG_TWO_A_FUNC,
  input wire logic [3:0] CFG_TWO_B_DATA,
  input wire logic CFG_TWO_B_FUNC,
  // three-input cell configuration
  input wire logic [7:0] CFG_THREE_A_DATA,
  input wire logic CFG_THREE_A_FUNC,
  input wire logic [7:0] CFG_THREE_B_DATA,
  input wire logic CFG_THREE_B_FUNC,
  // standalone storage configuration
  input wire logic [2:0] CFG_STORE_A,
  input wire logic [2:0] CFG_STORE_B,
  // four-input cell configuration
  input wire logic [15:0] CFG_FOUR_DATA,
  input wire logic [3:0] CFG_FOUR_COUNT,
  input wire logic CFG_FOUR_FUNC,
  // matrix inputs: storage cells use bit 0 data, bit 1 clock, bit 2 set/reset control (none on two-input cells); FOUR_IN bit 0 clocks the pattern
  input wire logic [1:0] TWO_A_IN,
  input wire logic [1:0] TWO_B_IN,
  input wire logic [2:0] THREE_A_IN,
  input wire logic [2:0] THREE_B_IN,
  input wire logic [2:0] STORE_A_IN,
  input wire logic [2:0] STORE_B_IN,
  input wire logic [3:0] FOUR_IN,
  // matrix outputs
  output logic TWO_A_OUT,
  output logic TWO_B_OUT,
  output logic THREE_A_OUT,
  output logic THREE_B_OUT,
  output logic STORE_A_OUT,
  output logic STORE_B_OUT,
  output logic FOUR_OUT
);

  localparam int N = cfmc_pkg::NUM_STORE;

  // per element storage settings, gathered so one loop serves all six
  logic [N-1:0] s_data;
  logic [N-1:0] s_clk;
  logic [N-1:0] s_ctl;
  logic [N-1:0] s_mode;
  logic [N-1:0] s_pol;
  logic [N-1:0] s_sr;
  logic [N-1:0] s_init;
  logic [N-1:0] s_out;

  // two-input cells: data bits reused as settings, top bit left unread
  assign s_data[cfmc_pkg::IDX_TWO_A] = TWO_A_IN[cfmc_pkg::IN_DATA];
  assign s_clk[cfmc_pkg::IDX_TWO_A] = TWO_A_IN[cfmc_pkg::IN_CLK];
  assign s_ctl[cfmc_pkg::IDX_TWO_A] = 1'b0; // no control input on this cell
  assign s_mode[cfmc_pkg::IDX_TWO_A] = CFG_TWO_A_DATA[cfmc_pkg::TWO_MODE_BIT];
  assign s_pol[cfmc_pkg::IDX_TWO_A] = CFG_TWO_A_DATA[cfmc_pkg::TWO_POL_BIT];
  assign s_sr[cfmc_pkg::IDX_TWO_A] = cfmc_pkg::SR_RESET;
  assign s_init[cfmc_pkg::IDX_TWO_A] = CFG_TWO_A_DATA[cfmc_pkg::TWO_INIT_BIT];
  assign s_data[cfmc_pkg::IDX_TWO_B] = TWO_B_IN[cfmc_pkg::IN_DATA];
  assign s_clk[cfmc_pkg::IDX_TWO_B] = TWO_B_IN[cfmc_pkg::IN_CLK];
  assign s_ctl[cfmc_pkg::IDX_TWO_B] = 1'b0;
  assign s_mode[cfmc_pkg::IDX_TWO_B] = CFG_TWO_B_DATA[cfmc_pkg::TWO_MODE_BIT];
  assign s_pol[cfmc_pkg::IDX_TWO_B] = CFG_TWO_B_DATA[cfmc_pkg::TWO_POL_BIT];
  assign s_sr[cfmc_pkg::IDX_TWO_B] = cfmc_pkg::SR_RESET;
  assign s_init[cfmc_pkg::IDX_TWO_B] = CFG_TWO_B_DATA[cfmc_pkg::TWO_INIT_BIT];

  // three-input cells: bits above the init bit are left unread
  assign s_data[cfmc_pkg::IDX_THREE_A] = THREE_A_IN[cfmc_pkg::IN_DATA];
  assign s_clk[cfmc_pkg::IDX_THREE_A] = THREE_A_IN[cfmc_pkg::IN_CLK];
  assign s_ctl[cfmc_pkg::IDX_THREE_A] = THREE_A_IN[cfmc_pkg::IN_CTL];
  assign s_mode[cfmc_pkg::IDX_THREE_A] = CFG_THREE_A_DATA[cfmc_pkg::THREE_MODE_BIT];
  assign s_pol[cfmc_pkg::IDX_THREE_A] = CFG_THREE_A_DATA[cfmc_pkg::THREE_POL_BIT];
  assign s_sr[cfmc_pkg::IDX_THREE_A] = CFG_THREE_A_DATA[cfmc_pkg::THREE_SR_BIT];
  assign s_init[cfmc_pkg::IDX_THREE_A] = CFG_THREE_A_DATA[cfmc_pkg::THREE_INIT_BIT];
  assign s_data[cfmc_pkg::IDX_THREE_B] = THREE_B_IN[cfmc_pkg::IN_DATA];
  assign s_clk[cfmc_pkg::IDX_THREE_B] = THREE_B_IN[cfmc_pkg::IN_CLK];
  assign s_ctl[cfmc_pkg::IDX_THREE_B] = THREE_B_IN[cfmc_pkg::IN_CTL];
  assign s_mode[cfmc_pkg::IDX_THREE_B] = CFG_THREE_B_DATA[cfmc_pkg::THREE_MODE_BIT];
  assign s_pol[cfmc_pkg::IDX_THREE_B] = CFG_THREE_B_DATA[cfmc_pkg::THREE_POL_BIT];
  assign s_sr[cfmc_pkg::IDX_THREE_B] = CFG_THREE_B_DATA[cfmc_pkg::THREE_SR_BIT];
  assign s_init[cfmc_pkg::IDX_THREE_B] = CFG_THREE_B_DATA[cfmc_pkg::THREE_INIT_BIT];

  // standalone cells have no polarity setting, output is always true
  assign s_data[cfmc_pkg::IDX_STORE_A] = STORE_A_IN[cfmc_pkg::IN_DATA];
  assign s_clk[cfmc_pkg::IDX_STORE_A] = STORE_A_IN[cfmc_pkg::IN_CLK];
  assign s_ctl[cfmc_pkg::IDX_STORE_A] = STORE_A_IN[cfmc_pkg::IN_CTL];
  assign s_mode[cfmc_pkg::IDX_STORE_A] = CFG_STORE_A[cfmc_pkg::ALONE_MODE_BIT];
  assign s_pol[cfmc_pkg::IDX_STORE_A] = 1'b0;
  assign s_sr[cfmc_pkg::IDX_STORE_A] = CFG_STORE_A[cfmc_pkg::ALONE_SR_BIT];
  assign s_init[cfmc_pkg::IDX_STORE_A] = CFG_STORE_A[cfmc_pkg::ALONE_INIT_BIT];
  assign s_data[cfmc_pkg::IDX_STORE_B] = STORE_B_IN[cfmc_pkg::IN_DATA];
  assign s_clk[cfmc_pkg::IDX_STORE_B] = STORE_B_IN[cfmc_pkg::IN_CLK];
  assign s_ctl[cfmc_pkg::IDX_STORE_B] = STORE_B_IN[cfmc_pkg::IN_CTL];
  assign s_mode[cfmc_pkg::IDX_STORE_B] = CFG_STORE_B[cfmc_pkg::ALONE_MODE_BIT];
  assign s_pol[cfmc_pkg::IDX_STORE_B] = 1'b0;
  assign s_sr[cfmc_pkg::IDX_STORE_B] = CFG_STORE_B[cfmc_pkg::ALONE_SR_BIT];
  assign s_init[cfmc_pkg::IDX_STORE_B] = CFG_STORE_B[cfmc_pkg::ALONE_INIT_BIT];

  // storage elements; the matrix clock is sampled on REF_CLK, so edges
  // are seen one reference cycle late and pulses shorter than 100 ns can be lost
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_store
      logic stored;
      logic clk_prev;
      logic next_stored;
      logic next_clk_prev;
      logic clk_rise;
      logic transparent;
      logic value;

      assign clk_rise = s_clk[gi] & ~clk_prev;
      assign transparent = (s_mode[gi] == cfmc_pkg::MODE_LATCH) & s_clk[gi];

      // present value: reset, then control override, then latch pass-through
      always_comb begin
        if (RST) begin
          value = s_init[gi];
        end else if (s_ctl[gi]) begin
          value = s_sr[gi];
        end else if (transparent) begin
          value = s_data[gi];
        end else begin
          value = stored;
        end
      end

      // next stored value; a flop captures only on a sampled rising edge
      always_comb begin
        next_clk_prev = s_clk[gi];
        if (RST) begin
          next_stored = s_init[gi];
        end else if (s_ctl[gi]) begin
          next_stored = s_sr[gi];
        end else if (transparent) begin
          next_stored = s_data[gi];
        end else if ((s_mode[gi] == cfmc_pkg::MODE_DFF) && clk_rise) begin
          next_stored = s_data[gi];
        end else begin
          next_stored = stored;
        end
      end

      // register; reset is taken even with the clock enable low
      always_ff @(posedge REF_CLK) begin
        if (CE || RST) begin
          stored <= next_stored;
          clk_prev <= next_clk_prev;
        end
      end

      assign s_out[gi] = value ^ s_pol[gi];
    end
  endgenerate

  // lookup outputs chosen by function select
  always_comb begin
    if (CFG_TWO_A_FUNC == cfmc_pkg::FUNC_LUT) begin
      TWO_A_OUT = CFG_TWO_A_DATA[TWO_A_IN];
    end else begin
      TWO_A_OUT = s_out[cfmc_pkg::IDX_TWO_A];
    end
    if (CFG_TWO_B_FUNC == cfmc_pkg::FUNC_LUT) begin
      TWO_B_OUT = CFG_TWO_B_DATA[TWO_B_IN];
    end else begin
      TWO_B_OUT = s_out[cfmc_pkg::IDX_TWO_B];
    end
    if (CFG_THREE_A_FUNC == cfmc_pkg::FUNC_LUT) begin
      THREE_A_OUT = CFG_THREE_A_DATA[THREE_A_IN];
    end else begin
      THREE_A_OUT = s_out[cfmc_pkg::IDX_THREE_A];
    end
    if (CFG_THREE_B_FUNC == cfmc_pkg::FUNC_LUT) begin
      THREE_B_OUT = CFG_THREE_B_DATA[THREE_B_IN];
    end else begin
      THREE_B_OUT = s_out[cfmc_pkg::IDX_THREE_B];
    end
    STORE_A_OUT = s_out[cfmc_pkg::IDX_STORE_A];
    STORE_B_OUT = s_out[cfmc_pkg::IDX_STORE_B];
  end

  // pattern generator: index walks 0..count and wraps
  logic [3:0] pat_idx;
  logic pat_clk_prev;
  logic [3:0] next_pat_idx;
  logic next_pat_clk_prev;
  logic pat_rise;

  assign pat_rise = FOUR_IN[cfmc_pkg::PAT_CLK_IN] & ~pat_clk_prev;

  // index held at zero in lookup use so a switch starts cleanly
  always_comb begin
    next_pat_clk_prev = FOUR_IN[cfmc_pkg::PAT_CLK_IN];
    next_pat_idx = pat_idx;
    if (RST || (CFG_FOUR_FUNC != cfmc_pkg::FUNC_PATTERN)) begin
      next_pat_idx = cfmc_pkg::PAT_IDX_RESET;
    end else if (pat_rise) begin
      if (pat_idx >= CFG_FOUR_COUNT) begin
        next_pat_idx = cfmc_pkg::PAT_IDX_RESET;
      end else begin
        next_pat_idx = pat_idx + 4'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (CE || RST) begin
      pat_idx <= next_pat_idx;
      pat_clk_prev <= next_pat_clk_prev;
    end
  end

  // one sixteen-bit field serves both uses
  always_comb begin
    if (CFG_FOUR_FUNC == cfmc_pkg::FUNC_LUT) begin
      FOUR_OUT = CFG_FOUR_DATA[FOUR_IN];
    end else begin
      FOUR_OUT = CFG_FOUR_DATA[pat_idx];
    end
  end

endmodule : cfmc_macrocells

/* File: tb/cfmc_macrocells_assertions.sv */
// port-level checker for the configurable macrocell block
`timescale 1ns/1ps
module cfmc_macrocells_chk (
  // clock, reset and enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // configuration
  input wire logic [3:0] CFG_TWO_B_DATA,
  input wire logic CFG_TWO_B_FUNC,
  input wire logic [7:0] CFG_THREE_B_DATA,
  input wire logic CFG_THREE_B_FUNC,
  input wire logic [2:0] CFG_STORE_A,
  input wire logic [2:0] CFG_STORE_B,
  input wire logic [15:0] CFG_FOUR_DATA,
  input wire logic CFG_FOUR_FUNC,
  // matrix inputs
  input wire logic [1:0] TWO_B_IN,
  input wire logic [2:0] THREE_B_IN,
  input wire logic [2:0] STORE_A_IN,
  input wire logic [2:0] STORE_B_IN,
  input wire logic [3:0] FOUR_IN,
  // matrix outputs
  input wire logic TWO_B_OUT,
  input wire logic THREE_B_OUT,
  input wire logic STORE_A_OUT,
  input wire logic STORE_B_OUT,
  input wire logic FOUR_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  AST_TWO_B_LUT: assert property (!CFG_TWO_B_FUNC |-> TWO_B_OUT == CFG_TWO_B_DATA[TWO_B_IN])
    else $error("two-input lookup output wrong");
  AST_THREE_B_LUT: assert property (!CFG_THREE_B_FUNC |-> THREE_B_OUT == CFG_THREE_B_DATA[THREE_B_IN])
    else $error("three-input lookup output wrong");
  AST_FOUR_LUT: assert property (!CFG_FOUR_FUNC |-> FOUR_OUT == CFG_FOUR_DATA[FOUR_IN])
    else $error("four-input lookup output wrong");
  // state loaded during reset must show on the first cycle after release
  AST_TWO_B_INIT: assert property ($fell(RST) && CFG_TWO_B_FUNC && !TWO_B_IN[1] && $stable(CFG_TWO_B_DATA)
    |-> TWO_B_OUT == (CFG_TWO_B_DATA[2] ^ CFG_TWO_B_DATA[1]))
    else $error("initial state not held after reset");
  AST_TWO_B_EDGE: assert property (CFG_TWO_B_FUNC && !CFG_TWO_B_DATA[0] && CE && $past(CE) && !$past(RST)
    && TWO_B_IN[1] && !$past(TWO_B_IN[1]) ##1 CFG_TWO_B_FUNC && $stable(CFG_TWO_B_DATA)
    |-> TWO_B_OUT == ($past(TWO_B_IN[0]) ^ CFG_TWO_B_DATA[1]))
    else $error("flop did not capture data on clock rise");
  AST_THREE_B_CTL: assert property (CFG_THREE_B_FUNC && THREE_B_IN[2]
    |-> THREE_B_OUT == (CFG_THREE_B_DATA[2] ^ CFG_THREE_B_DATA[1]))
    else $error("three-input cell control input ignored");
  AST_STORE_A_CTL: assert property (STORE_A_IN[2] |-> STORE_A_OUT == CFG_STORE_A[1])
    else $error("standalone set or reset ignored");
  AST_STORE_B_LATCH: assert property (CFG_STORE_B[0] && STORE_B_IN[1] && !STORE_B_IN[2]
    |-> STORE_B_OUT == STORE_B_IN[0])
    else $error("latch not transparent");
endmodule : cfmc_macrocells_chk

bind cfmc_macrocells cfmc_macrocells_chk cfmc_macrocells_chk_inst (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
  .CFG_TWO_B_DATA(CFG_TWO_B_DATA), .CFG_TWO_B_FUNC(CFG_TWO_B_FUNC), .CFG_THREE_B_DATA(CFG_THREE_B_DATA),
  .CFG_THREE_B_FUNC(CFG_THREE_B_FUNC), .CFG_STORE_A(CFG_STORE_A), .CFG_STORE_B(CFG_STORE_B),
  .CFG_FOUR_DATA(CFG_FOUR_DATA), .CFG_FOUR_FUNC(CFG_FOUR_FUNC), .TWO_B_IN(TWO_B_IN), .THREE_B_IN(THREE_B_IN),
  .STORE_A_IN(STORE_A_IN), .STORE_B_IN(STORE_B_IN), .FOUR_IN(FOUR_IN), .TWO_B_OUT(TWO_B_OUT),
  .THREE_B_OUT(THREE_B_OUT), .STORE_A_OUT(STORE_A_OUT), .STORE_B_OUT(STORE_B_OUT), .FOUR_OUT(FOUR_OUT));

/* File: tb/cfmc_matrix_model.sv */
// connection matrix model: one-shot clock pulses toward the cells
`timescale 1ns/1ps
module cfmc_matrix_model (
  // system clock and matrix clock line
  input wire logic ref_clk,
  output logic mclk
);
  initial mclk = 1'b0;
  // low, high, low again, so every pulse is one rise seen at a sampled edge
  task automatic pulse();
    @(negedge ref_clk) mclk = 1'b1;
    @(negedge ref_clk) mclk = 1'b0;
    @(negedge ref_clk);
  endtask : pulse
endmodule : cfmc_matrix_model

/* File: tb/cfmc_macrocells_tb_top.sv */
// self-checking bench for the configurable macrocell block
`timescale 1ns/1ps
module cfmc_macrocells_tb_top;
  logic ref_clk, rst, ce, mclk, two_a_f, two_b_f, three_a_f, three_b_f, four_f;
  logic two_a_o, two_b_o, three_a_o, three_b_o, store_a_o, store_b_o, four_o;
  logic [1:0] two_a_in, two_b_in;
  logic [2:0] store_a, store_b, three_a_in, three_b_in, store_a_in, store_b_in;
  logic [3:0] two_a_d, two_b_d, four_cnt, four_in;
  logic [7:0] three_a_d, three_b_d;
  logic [15:0] four_d;
  int failures, samples_checked;
  cfmc_macrocells cfmc_macrocells_inst (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .CFG_TWO_A_DATA(two_a_d),
    .CFG_TWO_A_FUNC(two_a_f), .CFG_TWO_B_DATA(two_b_d), .CFG_TWO_B_FUNC(two_b_f), .CFG_THREE_A_DATA(three_a_d),
    .CFG_THREE_A_FUNC(three_a_f), .CFG_THREE_B_DATA(three_b_d), .CFG_THREE_B_FUNC(three_b_f),
    .CFG_STORE_A(store_a), .CFG_STORE_B(store_b), .CFG_FOUR_DATA(four_d), .CFG_FOUR_COUNT(four_cnt),
    .CFG_FOUR_FUNC(four_f), .TWO_A_IN(two_a_in), .TWO_B_IN(two_b_in), .THREE_A_IN(three_a_in),
    .THREE_B_IN(three_b_in), .STORE_A_IN(store_a_in), .STORE_B_IN(store_b_in), .FOUR_IN(four_in | {3'h0, mclk}),
    .TWO_A_OUT(two_a_o), .TWO_B_OUT(two_b_o), .THREE_A_OUT(three_a_o), .THREE_B_OUT(three_b_o),
    .STORE_A_OUT(store_a_o), .STORE_B_OUT(store_b_o), .FOUR_OUT(four_o));
  cfmc_matrix_model cfmc_matrix_model_inst (.ref_clk(ref_clk), .mclk(mclk));
  // free-running 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // two-cycle reset with the two-input B and standalone A init bits set, then one quiet cycle
  task automatic t_reset();
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(two_b_o, 1'b0);
    chk(store_a_o, 1'b1);
    rst = 1'b0;
    @(negedge ref_clk);
  endtask : t_reset
  // every index of every lookup cell, tables chosen to differ from each other
  task automatic t_lut();
    {two_a_f, two_b_f, three_a_f, three_b_f, four_f} = 5'h00;
    {two_a_d, two_b_d, three_a_d, three_b_d, four_d} = {4'h6, 4'h9, 8'h96, 8'h3c, 16'h6ac5};
    for (int i = 0; i < 16; i++) begin
      {two_a_in, two_b_in, three_a_in, three_b_in, four_in} = {i[1:0], i[1:0], i[2:0], i[2:0], i[3:0]};
      @(negedge ref_clk);
      chk(two_a_o, two_a_d[i[1:0]]);
      chk(two_b_o, two_b_d[i[1:0]]);
      chk(three_a_o, three_a_d[i[2:0]]);
      chk(three_b_o, three_b_d[i[2:0]]);
      chk(four_o, four_d[i[3:0]]);
    end
  endtask : t_lut
  // flop with inverted output: capture both values, then hold and freeze
  task automatic t_flop();
    {two_b_f, two_b_d} = {1'b1, 4'b1010};
    for (int d = 0; d < 2; d++) begin
      two_b_in = 2'b00;
      @(negedge ref_clk);
      two_b_in = {1'b1, d[0]};
      @(negedge ref_clk);
      chk(two_b_o, ~d[0]);
    end
    two_b_in = 2'b10;
    @(negedge ref_clk);
    chk(two_b_o, 1'b0);
    {ce, two_b_in} = 3'b000;
    @(negedge ref_clk);
    two_b_in = 2'b10;
    repeat (2) @(negedge ref_clk);
    {ce, two_b_d} = {1'b1, 4'b0010};
    @(negedge ref_clk);
    chk(two_b_o, 1'b0);
  endtask : t_flop
  // control input as set on a three-input cell and as reset on a standalone cell
  task automatic t_ctl();
    {three_b_f, three_b_d, three_b_in, store_a_in} = {1'b1, 8'hf4, 3'b100, 3'b100};
    @(negedge ref_clk);
    chk(three_b_o, 1'b1);
    chk(store_a_o, 1'b0);
    {three_b_in, store_a_in} = 6'h00;
    @(negedge ref_clk);
    chk(three_b_o, 1'b1);
    {three_b_d, three_b_in} = {8'h06, 3'b100};
    @(negedge ref_clk);
    chk(three_b_o, 1'b0);
  endtask : t_ctl
  // standalone latch: open follows data, closed keeps last open value
  task automatic t_latch();
    logic [2:0] seq [6] = '{3'h3, 3'h2, 3'h0, 3'h1, 3'h3, 3'h1};
    logic [5:0] exp = 6'b110001;
    for (int i = 0; i < 6; i++) begin
      store_b_in = seq[i];
      @(negedge ref_clk);
      chk(store_b_o, exp[i]);
    end
  endtask : t_latch
  // last index 2, pattern picked so a missing wrap shows up
  task automatic t_pat();
    {four_cnt, four_d, four_f, four_in} = {4'h2, 16'h00fa, 1'b1, 4'h0};
    @(negedge ref_clk);
    chk(four_o, 1'b0);
    for (int k = 1; k < 5; k++) begin
      cfmc_matrix_model_inst.pulse();
      chk(four_o, four_d[k % 3]);
    end
  endtask : t_pat
  // modes the other scenarios leave unset: two-input latch, three-input flop with reset,
  // standalone flop with set, pattern frozen by the enable, and a second reset in mid-run
  task automatic t_mixed();
    {two_a_f, two_a_d, two_a_in} = {1'b1, 4'b1001, 2'b11};
    {three_a_f, three_a_d, three_a_in, store_b, store_b_in} = {1'b1, 8'hf0, 3'b100, 3'h2, 3'b100};
    @(negedge ref_clk);
    chk(two_a_o, 1'b1);
    chk(three_a_o, 1'b0);
    chk(store_b_o, 1'b1);
    {two_a_in, three_a_in, store_b_in} = {2'b10, 3'b011, 3'b010};
    @(negedge ref_clk);
    chk(two_a_o, 1'b0);
    chk(three_a_o, 1'b1);
    chk(store_b_o, 1'b0);
    // latch clock dropped so it must hold the old data, flop clocks held high so they must not capture
    {two_a_in, three_a_in, store_b_in} = {2'b01, 3'b010, 3'b011};
    @(negedge ref_clk);
    chk(two_a_o, 1'b0);
    chk(three_a_o, 1'b1);
    chk(store_b_o, 1'b0);
    ce = 1'b0;
    cfmc_matrix_model_inst.pulse();
    chk(four_o, four_d[1]);
    ce = 1'b1;
    cfmc_matrix_model_inst.pulse();
    chk(four_o, four_d[2]);
    // init values chosen to differ from what the cells currently hold
    {rst, store_b} = {1'b1, 3'h6};
    repeat (2) @(negedge ref_clk);
    chk(three_a_o, 1'b0);
    chk(store_b_o, 1'b1);
    rst = 1'b0;
    @(negedge ref_clk);
    chk(three_a_o, 1'b0);
    chk(store_b_o, 1'b1);
    cfmc_matrix_model_inst.pulse();
    chk(four_o, four_d[1]);
  endtask : t_mixed
  initial begin
    {failures, samples_checked, ce, rst} = {32'h0, 32'h0, 2'b11};
    {two_a_f, two_b_f, three_a_f, three_b_f, four_f} = 5'h08;
    {two_a_d, two_b_d, three_a_d, three_b_d, four_d, four_cnt} = {4'h0, 4'h6, 8'h00, 8'h00, 16'h0000, 4'h0};
    {store_a, store_b} = {3'h4, 3'h1};
    {two_a_in, two_b_in, three_a_in, three_b_in, store_a_in, store_b_in, four_in} = 20'h00000;
    t_reset();
    t_lut();
    t_flop();
    t_ctl();
    t_latch();
    t_pat();
    t_mixed();
    give_verdict();
  end
  // about 65 cycles expected; 3000 cycles means a hang
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
endmodule : cfmc_macrocells_tb_top
